// *** epd_pkg.sv ***
package epd_pkg;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_LATCH_ARM = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h42;
    localparam logic [7:0] CMD_SECTOR_WIPE = 8'hd8;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'hc7;
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] CMD_WAKE_SIGNATURE = 8'hab;
    localparam int SR_BUSY_POS = 0;
    localparam int SR_WEL_POS = 1;
    localparam int SR_BP_LO_POS = 2;
    localparam int SR_BP_HI_POS = 3;
    localparam int SR_PPE_POS = 7;
    localparam logic [2:0] NV_RESET = 3'h0;
    localparam int ADDR_BITS = 17;
    localparam logic [16:0] QUARTER_BASE = 17'h18000;
    localparam logic [16:0] HALF_BASE = 17'h10000;
    localparam int CMD_BITS = 8;
    localparam int ADDR_END_BITS = 32;
    localparam int STATUS_END_BITS = 16;
    localparam int CLK_MHZ = 40;
    localparam int PAGE_ERASE_US = 6000;
    localparam int CHIP_ERASE_US = 10000;
    localparam int SLEEP_SETTLE_US = 10;
    localparam int WAKE_RELEASE_US = 10;
    localparam int PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
    localparam int CHIP_ERASE_CYC = CHIP_ERASE_US * CLK_MHZ;
    localparam int SLEEP_SETTLE_CYC = SLEEP_SETTLE_US * CLK_MHZ;
    localparam int WAKE_RELEASE_CYC = WAKE_RELEASE_US * CLK_MHZ;
    localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5a;

    function automatic logic addr_locked(input logic [1:0] bp, input logic [16:0] a);
        unique case (bp)
            2'b00: addr_locked = 1'b0;
            2'b01: addr_locked = (a >= QUARTER_BASE);
            2'b10: addr_locked = (a >= HALF_BASE);
            default: addr_locked = 1'b1;
        endcase
    endfunction : addr_locked
endpackage : epd_pkg

// *** epd_timer.sv ***
`timescale 1ns/1ps
module epd_timer #(
    parameter int WIDTH = 20
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_busy,
    output logic o_done
);
    logic [WIDTH-1:0] cnt_reg;
    initial begin
        if (WIDTH < 2) $error("epd_timer WIDTH too small");
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= '0;
        end else if (i_start) begin
            cnt_reg <= i_count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
    assign o_busy = (cnt_reg != '0);
    assign o_done = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule : epd_timer

// *** epd_frame.sv ***
`timescale 1ns/1ps
module epd_frame (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    output logic o_rise,
    output logic o_fall,
    output logic o_sel_start,
    output logic o_desel,
    output logic [31:0] o_shift,
    output logic [5:0] o_count
);
    logic sck_d_reg;
    logic cs_d_reg;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            sck_d_reg <= i_sck;
            cs_d_reg <= i_cs_n;
        end
    end
    assign o_rise = i_sck && !sck_d_reg && !i_cs_n;
    assign o_fall = !i_sck && sck_d_reg && !i_cs_n;
    assign o_sel_start = cs_d_reg && !i_cs_n;
    assign o_desel = !cs_d_reg && i_cs_n;
    // Counter saturates so overlong frames never alias to a valid length
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_shift <= '0;
            o_count <= '0;
        end else if (o_sel_start) begin
            o_shift <= '0;
            o_count <= '0;
        end else if (o_rise) begin
            o_shift <= {o_shift[30:0], i_si};
            if (o_count != 6'h3f) begin
                o_count <= o_count + 6'h01;
            end
        end
    end
endmodule : epd_frame

// *** epd_core.sv ***
`timescale 1ns/1ps
module epd_core
    import epd_pkg::*;
#(
    parameter int PAGE_ERASE_CYCLES = epd_pkg::PAGE_ERASE_CYC,
    parameter int SECTOR_ERASE_CYCLES = epd_pkg::CHIP_ERASE_CYC,
    parameter int CHIP_ERASE_CYCLES = epd_pkg::CHIP_ERASE_CYC,
    parameter int SLEEP_SETTLE_CYCLES = epd_pkg::SLEEP_SETTLE_CYC,
    parameter int WAKE_RELEASE_CYCLES = epd_pkg::WAKE_RELEASE_CYC,
    parameter logic [7:0] SIGNATURE = epd_pkg::SIGNATURE_DEFAULT
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    output logic [7:0] o_status,
    output logic o_sleeping,
    output logic o_erase_pulse,
    output logic [1:0] o_erase_kind,
    output logic [16:0] o_erase_addr
);
    import epd_pkg::*;

    localparam int TW = 20;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_BUSY = 5'b00010,
        ST_SETTLE = 5'b00100,
        ST_SLEEP = 5'b01000,
        ST_WAKE = 5'b10000
    } epd_state_e;

    initial begin
        if (PAGE_ERASE_CYCLES < 1 || PAGE_ERASE_CYCLES >= (1 << TW)) $error("bad page time");
        if (SECTOR_ERASE_CYCLES < 1 || SECTOR_ERASE_CYCLES >= (1 << TW)) $error("bad sector time");
        if (CHIP_ERASE_CYCLES < 1 || CHIP_ERASE_CYCLES >= (1 << TW)) $error("bad chip time");
        if (SLEEP_SETTLE_CYCLES < 1 || WAKE_RELEASE_CYCLES < 1) $error("bad delay");
    end

    epd_state_e state_reg;
    logic [2:0] nv_reg;
    logic wel_reg;
    logic [7:0] out_sh_reg;
    logic out_en_reg;
    logic wake_pending_reg;
    logic [7:0] cmd_reg;
    logic [2:0] bit_ph_reg;

    logic rise;
    logic fall;
    logic sel_start;
    logic desel;
    logic [31:0] shift;
    logic [5:0] count;
    logic t_start;
    logic [TW-1:0] t_count;
    logic t_busy;
    logic t_done;

    epd_frame u_frame (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_cs_n(i_cs_n),
        .i_sck(i_sck),
        .i_si(i_si),
        .o_rise(rise),
        .o_fall(fall),
        .o_sel_start(sel_start),
        .o_desel(desel),
        .o_shift(shift),
        .o_count(count)
    );

    epd_timer #(.WIDTH(TW)) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_start(t_start),
        .i_count(t_count),
        .o_busy(t_busy),
        .o_done(t_done)
    );

    logic [1:0] bp;
    logic pin_protect;
    logic [16:0] frame_addr;
    logic busy;
    logic at_cmd;
    logic at_addr;
    logic at_status;
    logic [7:0] frame_cmd;
    logic do_status_write;
    logic do_page;
    logic do_sector;
    logic do_chip;
    logic do_sleep;
    logic do_latch_arm;
    logic do_latch_clear;
    logic sig_start;

    assign bp = nv_reg[1:0];
    assign busy = (state_reg == ST_BUSY);
    assign pin_protect = !i_wp_n && nv_reg[2];
    assign frame_addr = shift[ADDR_BITS-1:0];
    assign frame_cmd = (count == 6'(CMD_BITS)) ? shift[7:0] : cmd_reg;
    assign at_cmd = desel && (count == 6'(CMD_BITS));
    assign at_addr = desel && (count == 6'(ADDR_END_BITS));
    assign at_status = desel && (count == 6'(STATUS_END_BITS));

    // Commands other than the wake signature and status read decode only at deselect with an exact bit count
    assign do_latch_arm = at_cmd && cmd_reg == CMD_LATCH_ARM && state_reg == ST_IDLE;
    assign do_latch_clear = at_cmd && cmd_reg == CMD_LATCH_CLEAR && state_reg == ST_IDLE;
    assign do_status_write = at_status && cmd_reg == CMD_STATUS_WRITE && state_reg == ST_IDLE
        && wel_reg && !pin_protect;
    assign do_page = at_addr && cmd_reg == CMD_PAGE_ERASE && state_reg == ST_IDLE && wel_reg
        && !addr_locked(bp, frame_addr);
    assign do_sector = at_addr && cmd_reg == CMD_SECTOR_WIPE && state_reg == ST_IDLE && wel_reg
        && !addr_locked(bp, frame_addr);
    assign do_chip = at_cmd && cmd_reg == CMD_CHIP_ERASE && state_reg == ST_IDLE && wel_reg
        && bp == 2'b00;
    assign do_sleep = at_cmd && cmd_reg == CMD_DEEP_SLEEP && state_reg == ST_IDLE;
    assign sig_start = rise && count == 6'(ADDR_END_BITS - 1) && cmd_reg == CMD_WAKE_SIGNATURE
        && (state_reg == ST_SLEEP || state_reg == ST_IDLE);

    always_comb begin
        t_start = 1'b0;
        t_count = '0;
        if (do_page) begin
            t_start = 1'b1;
            t_count = TW'(PAGE_ERASE_CYCLES);
        end else if (do_sector) begin
            t_start = 1'b1;
            t_count = TW'(SECTOR_ERASE_CYCLES);
        end else if (do_chip) begin
            t_start = 1'b1;
            t_count = TW'(CHIP_ERASE_CYCLES);
        end else if (do_status_write) begin
            t_start = 1'b1;
            t_count = TW'(PAGE_ERASE_CYCLES);
        end else if (do_sleep) begin
            t_start = 1'b1;
            t_count = TW'(SLEEP_SETTLE_CYCLES);
        end else if (state_reg == ST_SLEEP && desel && wake_pending_reg) begin
            t_start = 1'b1;
            t_count = TW'(WAKE_RELEASE_CYCLES);
        end
    end

    // Opcode held after the eighth bit
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmd_reg <= 8'h00;
        end else if (sel_start) begin
            cmd_reg <= 8'h00;
        end else if (rise && count == 6'(CMD_BITS - 1)) begin
            cmd_reg <= {shift[6:0], i_si};
        end
    end

    // Bit position in the byte; wraps every eight bits and keeps counting after the frame counter saturates
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_ph_reg <= 3'h0;
        end else if (sel_start) begin
            bit_ph_reg <= 3'h0;
        end else if (rise) begin
            bit_ph_reg <= bit_ph_reg + 3'h1;
        end
    end

    // Wake seen in sleep; release happens at deselect
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wake_pending_reg <= 1'b0;
        end else if (state_reg != ST_SLEEP || sel_start) begin
            wake_pending_reg <= 1'b0;
        end else if (rise && count == 6'(CMD_BITS - 1) && {shift[6:0], i_si} == CMD_WAKE_SIGNATURE) begin
            wake_pending_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (do_page || do_sector || do_chip || do_status_write) begin
                        state_reg <= ST_BUSY;
                    end else if (do_sleep) begin
                        state_reg <= ST_SETTLE;
                    end
                end
                ST_BUSY: begin
                    if (t_done) state_reg <= ST_IDLE;
                end
                ST_SETTLE: begin
                    if (t_done) state_reg <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    // Standby only after the release delay; commands wait it out
                    if (desel && wake_pending_reg) state_reg <= ST_WAKE;
                end
                ST_WAKE: begin
                    if (t_done) state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Nonvolatile bits modelled as reset-to-default flops
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            nv_reg <= NV_RESET;
        end else if (do_status_write) begin
            nv_reg <= {shift[SR_PPE_POS], shift[SR_BP_HI_POS], shift[SR_BP_LO_POS]};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wel_reg <= 1'b0;
        end else if (busy && t_done) begin
            wel_reg <= 1'b0;
        end else if (do_latch_arm) begin
            wel_reg <= 1'b1;
        end else if (do_latch_clear) begin
            wel_reg <= 1'b0;
        end
    end

    // Output: status read or signature; released while deselected, settling into sleep or waking; a signature read drives it during sleep
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            out_sh_reg <= 8'h00;
            out_en_reg <= 1'b0;
        end else if (i_cs_n || state_reg == ST_SETTLE || state_reg == ST_WAKE) begin
            out_en_reg <= 1'b0;
        end else if (sig_start) begin
            out_sh_reg <= SIGNATURE;
            out_en_reg <= 1'b1;
        end else if (rise && count == 6'(CMD_BITS - 1) && {shift[6:0], i_si} == CMD_STATUS_READ
            && state_reg != ST_SLEEP) begin
            out_sh_reg <= o_status;
            out_en_reg <= 1'b1;
        end else if (fall && out_en_reg && count > 6'(CMD_BITS) && bit_ph_reg == 3'h0) begin
            if (frame_cmd == CMD_WAKE_SIGNATURE) begin
                out_sh_reg <= SIGNATURE;
            end else begin
                out_sh_reg <= o_status;
            end
        end else if (fall && out_en_reg && bit_ph_reg != 3'h0) begin
            out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
    end

    assign o_so = out_sh_reg[7];
    assign o_so_oe = out_en_reg;
    assign o_status = {nv_reg[2], 3'h0, nv_reg[1:0], wel_reg, busy};
    // A recognised wake command clears the sleep flag at once; the release starts at deselect
    assign o_sleeping = (state_reg == ST_SLEEP) && !wake_pending_reg;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_erase_pulse <= 1'b0;
            o_erase_kind <= 2'h0;
            o_erase_addr <= '0;
        end else begin
            o_erase_pulse <= do_page || do_sector || do_chip;
            if (do_page || do_sector || do_chip) begin
                o_erase_kind <= do_page ? 2'h1 : (do_sector ? 2'h2 : 2'h3);
                o_erase_addr <= frame_addr;
            end
        end
    end
endmodule : epd_core

// *** epd_core_properties.sv ***
`timescale 1ns/1ps
module epd_core_chk (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic o_so_oe,
    input wire logic [7:0] o_status,
    input wire logic o_sleeping,
    input wire logic o_erase_pulse,
    input wire logic [1:0] o_erase_kind,
    input wire logic [16:0] o_erase_addr
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    a_pulse_single: assert property (o_erase_pulse |=> !o_erase_pulse)
        else $error("erase pulse too long");
    a_pulse_busy: assert property (o_erase_pulse |-> o_status[0])
        else $error("erase without busy");
    a_pulse_deselected: assert property (o_erase_pulse |-> i_cs_n)
        else $error("erase while selected");
    a_chip_unprot: assert property (o_erase_pulse && o_erase_kind == 2'h3 |-> o_status[3:2] == 2'h0)
        else $error("chip erase while protected");
    a_erase_unlocked: assert property (o_erase_pulse && o_erase_kind != 2'h3 |->
        o_status[3:2] == 2'h0 || (o_status[3:2] == 2'h1 && o_erase_addr < 17'h18000) ||
        (o_status[3:2] == 2'h2 && o_erase_addr < 17'h10000)) else $error("protected erase");
    a_busy_hold: assert property ($rose(o_status[0]) |-> o_status[0] [*8])
        else $error("busy dropped early");
    a_sleep_frozen: assert property (o_sleeping && $past(o_sleeping) |-> $stable(o_status))
        else $error("state moved in sleep");
    a_sleep_quiet: assert property (o_sleeping |-> !o_so_oe)
        else $error("output driven in sleep");
    a_nv_needs_wel: assert property ($changed(o_status[7:2]) |-> o_status[1] || $past(o_status[1]))
        else $error("status written without latch");
endmodule : epd_core_chk

bind epd_core epd_core_chk epd_core_chk_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_cs_n(i_cs_n), .o_so_oe(o_so_oe), .o_status(o_status), .o_sleeping(o_sleeping),
    .o_erase_pulse(o_erase_pulse), .o_erase_kind(o_erase_kind), .o_erase_addr(o_erase_addr));

// *** epd_host.sv ***
`timescale 1ns/1ps
module epd_host (
    input wire logic i_ref_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    int hp = 2;
    logic [7:0] rx;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    // Msb first; serial clock idles low outside frames
    task automatic xfer(input logic [47:0] d, input int n);
        rx = 8'h00;
        @(posedge i_ref_clk) o_cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_ref_clk) o_si <= d[i];
            o_sck <= 1'b0;
            repeat (hp) @(posedge i_ref_clk);
            o_sck <= 1'b1;
            repeat (hp) @(posedge i_ref_clk);
            @(negedge i_ref_clk) rx = {rx[6:0], i_so_oe ? i_so : 1'b0};
        end
        @(posedge i_ref_clk) o_sck <= 1'b0;
        // Deselect right after the last bit
        @(posedge i_ref_clk) o_cs_n <= 1'b1;
        o_si <= ~o_si;
        repeat (2) @(posedge i_ref_clk);
    endtask : xfer
endmodule : epd_host

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import epd_pkg::*;
    localparam logic [7:0] SIG = 8'ha6; // Arbitrary value
    logic i_ref_clk, i_nrst, i_wp_n, i_cs_n, i_sck, i_si, o_so, o_so_oe, o_sleeping, o_erase_pulse;
    logic [7:0] o_status;
    logic [1:0] o_erase_kind, kind_seen;
    logic [16:0] o_erase_addr, addr_seen, a;
    logic [16:0] addrs [4] = '{17'h0ffff, 17'h10000, 17'h17fff, 17'h18000};
    logic ok;
    int mismatches = 0;
    int n_tests = 0;
    int pulses = 0;
    int p;
    // Erase long enough for a whole frame to land inside it
    epd_core #(.PAGE_ERASE_CYCLES(1000), .SECTOR_ERASE_CYCLES(1000), .CHIP_ERASE_CYCLES(1000),
        .SLEEP_SETTLE_CYCLES(20), .WAKE_RELEASE_CYCLES(20), .SIGNATURE(SIG)) epd_core_inst (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si),
        .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_status(o_status),
        .o_sleeping(o_sleeping), .o_erase_pulse(o_erase_pulse), .o_erase_kind(o_erase_kind),
        .o_erase_addr(o_erase_addr));
    epd_host epd_host_inst (.i_ref_clk(i_ref_clk), .i_so(o_so), .i_so_oe(o_so_oe),
        .o_cs_n(i_cs_n), .o_sck(i_sck), .o_si(i_si));
    always @(posedge i_ref_clk) begin
        if (o_erase_pulse === 1'b1) begin
            pulses <= pulses + 1;
            kind_seen <= o_erase_kind;
            addr_seen <= o_erase_addr;
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic check(input string w, input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    task automatic tx(input logic [47:0] d, input int n);
        epd_host_inst.xfer(d, n);
    endtask : tx
    task automatic idle();
        int k;
        k = 0;
        while (o_status[0] !== 1'b0 && k < 3000) begin
            @(negedge i_ref_clk);
            k++;
        end
        if (k >= 3000) begin
            mismatches++;
            end_of_test();
        end
    endtask : idle
    task automatic set_sr(input logic [7:0] v);
        tx(CMD_LATCH_ARM, 8);
        tx({CMD_STATUS_WRITE, v}, 16);
        idle();
    endtask : set_sr
    task automatic erase(input logic [47:0] d, input int n, input logic good, input logic [1:0] k);
        p = pulses;
        tx(CMD_LATCH_ARM, 8);
        tx(d, n);
        idle();
        check("erase count", 17'(pulses - p), {16'h0, good});
        check("latch", o_status[1], !good);
        if (good) check("kind", kind_seen, k);
        if (good && k != 2'h3) check("addr", addr_seen, d[16:0]);
    endtask : erase
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        i_nrst = 1'b0;
        i_wp_n = 1'b1;
        repeat (8) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        @(negedge i_ref_clk);
        check("status", o_status, 8'h00);
        check("so enable", o_so_oe, 1'b0);
        tx({CMD_STATUS_WRITE, 8'h84}, 16);
        idle();
        check("status", o_status, 8'h00);
        set_sr(8'hfe);
        check("status", o_status, 8'h8c);
        @(posedge i_ref_clk) i_wp_n <= 1'b0;
        set_sr(8'h00);
        check("status", o_status, 8'h8e);
        tx(CMD_LATCH_CLEAR, 8);
        @(posedge i_ref_clk) i_wp_n <= 1'b1;
        set_sr(8'h04);
        check("status", o_status, 8'h04);
        @(posedge i_ref_clk) i_wp_n <= 1'b0;
        set_sr(8'h00);
        check("status", o_status, 8'h00);
        erase({CMD_PAGE_ERASE, 24'h000100}, 32, 1'b1, 2'h1);
        @(posedge i_ref_clk) i_wp_n <= 1'b1;
        for (int b = 1; b < 4; b++) begin
            set_sr({4'h0, 2'(b), 2'h0});
            for (int j = 0; j < 4; j++) begin
                a = addrs[j];
                ok = (b == 1) ? (a < 17'h18000) : (b == 2) ? (a < 17'h10000) : 1'b0;
                erase({j[0] ? CMD_SECTOR_WIPE : CMD_PAGE_ERASE, 7'h7f, a}, 32, ok,
                    j[0] ? 2'h2 : 2'h1);
            end
        end
        set_sr(8'h04);
        erase(CMD_CHIP_ERASE, 8, 1'b0, 2'h3);
        set_sr(8'h00);
        erase({CMD_CHIP_ERASE, 1'b0}, 9, 1'b0, 2'h3);
        erase(CMD_CHIP_ERASE, 8, 1'b1, 2'h3);
        tx(CMD_LATCH_ARM, 8);
        tx({CMD_PAGE_ERASE, 24'h000200}, 32);
        // Let the pulse of this erase reach the counter first
        @(negedge i_ref_clk);
        p = pulses;
        tx({CMD_STATUS_READ, 8'h00}, 16);
        check("busy read", epd_host_inst.rx[0], 1'b1);
        tx({CMD_PAGE_ERASE, 24'h000300}, 32);
        tx({CMD_WAKE_SIGNATURE, 32'h0}, 40);
        check("signature", epd_host_inst.rx, 8'h00);
        idle();
        check("erase count", 17'(pulses - p), 17'h0);
        tx({CMD_WAKE_SIGNATURE, 32'h0}, 40);
        check("signature", epd_host_inst.rx, SIG);
        tx({CMD_DEEP_SLEEP, 1'b0}, 9);
        repeat (40) @(negedge i_ref_clk);
        check("sleeping", o_sleeping, 1'b0);
        tx(CMD_DEEP_SLEEP, 8);
        repeat (40) @(negedge i_ref_clk);
        check("sleeping", o_sleeping, 1'b1);
        tx(CMD_LATCH_ARM, 8);
        check("status", o_status, 8'h00);
        epd_host_inst.hp = 4;
        tx({CMD_WAKE_SIGNATURE, 40'h0}, 48);
        check("signature", epd_host_inst.rx, SIG);
        check("sleeping", o_sleeping, 1'b0);
        epd_host_inst.hp = 2;
        tx(CMD_DEEP_SLEEP, 8);
        repeat (40) @(negedge i_ref_clk);
        check("sleeping", o_sleeping, 1'b1);
        tx(CMD_WAKE_SIGNATURE, 8);
        check("sleeping", o_sleeping, 1'b0);
        repeat (40) @(negedge i_ref_clk);
        check("sleeping", o_sleeping, 1'b0);
        end_of_test();
    end
endmodule : testbench
